/* File: hw/motion_activity_detector.sv */
// motion (wake-up) and activity/inactivity detector with AXI4-Lite registers
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module motion_activity_detector #(
	parameter int DATA_W = 16
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [motion_activity_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [motion_activity_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	// axi4-lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// accelerometer samples, one strobe per output-data period
	input wire logic sample_valid,
	input wire logic signed [DATA_W-1:0] accel_x,
	input wire logic signed [DATA_W-1:0] accel_y,
	input wire logic signed [DATA_W-1:0] accel_z,
	input wire logic signed [DATA_W-1:0] hp_x,
	input wire logic signed [DATA_W-1:0] hp_y,
	input wire logic signed [DATA_W-1:0] hp_z,
	// interrupt pins
	output logic irq_pin_a,
	output logic irq_pin_b
);

	function automatic logic [6:0] word_index(input logic [motion_activity_pkg::ADDR_W-1:0] addr);
		word_index = addr[motion_activity_pkg::ADDR_W-1:2];
	endfunction : word_index

	// configuration registers
	logic [7:0] filter_latch_config, next_filter_latch_config;
	logic [7:0] motion_threshold_config, next_motion_threshold_config;
	logic [7:0] motion_duration_config, next_motion_duration_config;
	logic [7:0] pin_a_event_route, next_pin_a_event_route;
	logic [7:0] pin_b_event_route, next_pin_b_event_route;
	logic [7:0] function_enable, next_function_enable;
	logic [7:0] pin_ctrl, next_pin_ctrl;

	// bus state
	logic aw_held, next_aw_held;
	logic w_held, next_w_held;
	logic [6:0] aw_index, next_aw_index;
	logic [7:0] w_byte, next_w_byte;
	logic w_lane, next_w_lane;
	logic next_bvalid, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic source_read;

	// detection state
	logic signed [DATA_W-1:0] prev [3];
	logic signed [DATA_W-1:0] next_prev [3];
	logic [2:0] motion_run, next_motion_run;
	logic [motion_activity_pkg::IDLE_CNT_W-1:0] idle_cnt, next_idle_cnt;
	logic idle_state, next_idle_state;
	logic motion_pulse, next_motion_pulse;
	logic change_pulse, next_change_pulse;
	logic [2:0] axis_hit, next_axis_hit;
	logic motion_latch, next_motion_latch;
	logic change_latch, next_change_latch;
	logic [2:0] axis_latch, next_axis_latch;
	logic clear_req, next_clear_req;
	logic next_irq_pin_a, next_irq_pin_b;

	// configuration decode
	logic enable, hp_select, latch_irq, state_level, merge;
	logic [DATA_W-1:0] threshold;
	logic [1:0] motion_duration;
	logic [3:0] idle_duration;
	logic [motion_activity_pkg::IDLE_CNT_W-1:0] idle_limit;
	logic latch_motion, latch_change;
	logic motion_flag, change_flag;
	logic [2:0] axis_flag;
	logic [2:0] over;
	logic any_over, motion_now, go_idle;
	logic signed [DATA_W-1:0] cur [3];
	logic signed [DATA_W-1:0] hp [3];
	logic signed [DATA_W-1:0] filt [3];
	logic [DATA_W-1:0] mag [3];
	logic [7:0] motion_src_value, combined_src_value;

	assign enable = function_enable[motion_activity_pkg::FE_ENABLE];
	assign hp_select = filter_latch_config[motion_activity_pkg::FL_HP_SELECT];
	assign latch_irq = filter_latch_config[motion_activity_pkg::FL_LATCH_IRQ];
	assign state_level = filter_latch_config[motion_activity_pkg::FL_STATE_LEVEL];
	assign merge = pin_ctrl[motion_activity_pkg::PC_MERGE];
	assign motion_duration = motion_duration_config[motion_activity_pkg::DU_MOTION_LSB +: motion_activity_pkg::DU_MOTION_W];
	assign idle_duration = motion_duration_config[motion_activity_pkg::DU_IDLE_LSB +: motion_activity_pkg::DU_IDLE_W];

	// threshold in data counts; 16-bit data spans full scale over 2^15
	assign threshold = motion_duration_config[motion_activity_pkg::DU_WEIGHT]
		? DATA_W'({motion_threshold_config[motion_activity_pkg::TH_LSB +: motion_activity_pkg::TH_W]} << motion_activity_pkg::TH_SHIFT_FINE)
		: DATA_W'({motion_threshold_config[motion_activity_pkg::TH_LSB +: motion_activity_pkg::TH_W]} << motion_activity_pkg::TH_SHIFT_COARSE);

	assign idle_limit = (idle_duration == 4'h0)
		? motion_activity_pkg::IDLE_CNT_W'(motion_activity_pkg::IDLE_MIN)
		: motion_activity_pkg::IDLE_CNT_W'(idle_duration * motion_activity_pkg::IDLE_UNIT);

	assign cur[0] = accel_x;
	assign cur[1] = accel_y;
	assign cur[2] = accel_z;
	assign hp[0] = hp_x;
	assign hp[1] = hp_y;
	assign hp[2] = hp_z;

	// per-axis filter, magnitude and compare
	for (genvar a = 0; a < 3; a++)
	begin : g_axis
		logic signed [DATA_W:0] diff;
		assign diff = {cur[a][DATA_W-1], cur[a]} - {prev[a][DATA_W-1], prev[a]};
		assign filt[a] = hp_select ? hp[a] : diff[DATA_W:1];
		assign mag[a] = filt[a][DATA_W-1] ? DATA_W'(-filt[a]) : filt[a];
		assign over[a] = mag[a] > threshold;
	end

	assign any_over = |over;
	// a latched event needs a route; state-level mode never latches the state-change event
	assign latch_motion = latch_irq && (pin_a_event_route[motion_activity_pkg::RT_MOTION]
		|| pin_b_event_route[motion_activity_pkg::RT_MOTION]);
	assign latch_change = latch_irq && !state_level && (pin_a_event_route[motion_activity_pkg::RT_STATE_CHANGE]
		|| pin_b_event_route[motion_activity_pkg::RT_STATE_CHANGE]);
	assign motion_flag = latch_motion ? motion_latch : motion_pulse;
	assign change_flag = latch_change ? change_latch : change_pulse;
	assign axis_flag = latch_motion ? axis_latch : axis_hit;

	assign motion_src_value = {2'b00, change_flag, idle_state, motion_flag, axis_flag};
	assign combined_src_value = {6'h00, change_flag, motion_flag};

	// bus handshakes; write address and data taken in either order
	assign awready = !aw_held && !bvalid;
	assign wready = !w_held && !bvalid;
	assign arready = !rvalid;
	assign source_read = arvalid && arready && (word_index(araddr) == motion_activity_pkg::IDX_MOTION_SRC
		|| word_index(araddr) == motion_activity_pkg::IDX_COMBINED_SRC);

	always_comb
	begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_index = aw_index;
		next_w_byte = w_byte;
		next_w_lane = w_lane;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rresp = rresp;
		next_rdata = rdata;
		next_filter_latch_config = filter_latch_config;
		next_motion_threshold_config = motion_threshold_config;
		next_motion_duration_config = motion_duration_config;
		next_pin_a_event_route = pin_a_event_route;
		next_pin_b_event_route = pin_b_event_route;
		next_function_enable = function_enable;
		next_pin_ctrl = pin_ctrl;
		if (awvalid && awready)
		begin
			next_aw_held = 1'b1;
			next_aw_index = word_index(awaddr);
		end
		if (wvalid && wready)
		begin
			next_w_held = 1'b1;
			next_w_byte = wdata[7:0];
			next_w_lane = wstrb[0];
		end
		if (aw_held && w_held)
		begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = motion_activity_pkg::RESP_OKAY;
			// source registers are read-only; writing them changes nothing
			case (aw_index)
				motion_activity_pkg::IDX_FILTER_LATCH:
					if (w_lane) next_filter_latch_config = w_byte;
				motion_activity_pkg::IDX_THRESHOLD:
					if (w_lane) next_motion_threshold_config = w_byte;
				motion_activity_pkg::IDX_DURATION:
					if (w_lane) next_motion_duration_config = w_byte;
				motion_activity_pkg::IDX_ROUTE_A:
					if (w_lane) next_pin_a_event_route = w_byte;
				motion_activity_pkg::IDX_ROUTE_B:
					if (w_lane) next_pin_b_event_route = w_byte;
				motion_activity_pkg::IDX_FUNC_ENABLE:
					if (w_lane) next_function_enable = w_byte;
				motion_activity_pkg::IDX_PIN_CTRL:
					if (w_lane) next_pin_ctrl = w_byte;
				motion_activity_pkg::IDX_MOTION_SRC, motion_activity_pkg::IDX_COMBINED_SRC:
					next_bresp = motion_activity_pkg::RESP_OKAY;
				default:
					next_bresp = motion_activity_pkg::RESP_SLVERR;
			endcase
		end
		else if (bvalid && bready)
			next_bvalid = 1'b0;
		if (arvalid && arready)
		begin
			next_rvalid = 1'b1;
			next_rresp = motion_activity_pkg::RESP_OKAY;
			next_rdata = 32'h0000_0000;
			case (word_index(araddr))
				motion_activity_pkg::IDX_FILTER_LATCH: next_rdata[7:0] = filter_latch_config;
				motion_activity_pkg::IDX_THRESHOLD: next_rdata[7:0] = motion_threshold_config;
				motion_activity_pkg::IDX_DURATION: next_rdata[7:0] = motion_duration_config;
				motion_activity_pkg::IDX_ROUTE_A: next_rdata[7:0] = pin_a_event_route;
				motion_activity_pkg::IDX_ROUTE_B: next_rdata[7:0] = pin_b_event_route;
				motion_activity_pkg::IDX_FUNC_ENABLE: next_rdata[7:0] = function_enable;
				motion_activity_pkg::IDX_PIN_CTRL: next_rdata[7:0] = pin_ctrl;
				motion_activity_pkg::IDX_MOTION_SRC: next_rdata[7:0] = motion_src_value;
				motion_activity_pkg::IDX_COMBINED_SRC: next_rdata[7:0] = combined_src_value;
				default: next_rresp = motion_activity_pkg::RESP_SLVERR;
			endcase
		end
		else if (rvalid && rready)
			next_rvalid = 1'b0;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_index <= 7'h00;
			w_byte <= 8'h00;
			w_lane <= 1'b0;
			bvalid <= 1'b0;
			bresp <= motion_activity_pkg::RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= motion_activity_pkg::RESP_OKAY;
			rdata <= 32'h0000_0000;
			filter_latch_config <= motion_activity_pkg::CFG_RESET;
			motion_threshold_config <= motion_activity_pkg::CFG_RESET;
			motion_duration_config <= motion_activity_pkg::CFG_RESET;
			pin_a_event_route <= motion_activity_pkg::CFG_RESET;
			pin_b_event_route <= motion_activity_pkg::CFG_RESET;
			function_enable <= motion_activity_pkg::CFG_RESET;
			pin_ctrl <= motion_activity_pkg::CFG_RESET;
		end
		else
		begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_index <= next_aw_index;
			w_byte <= next_w_byte;
			w_lane <= next_w_lane;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
			filter_latch_config <= next_filter_latch_config;
			motion_threshold_config <= next_motion_threshold_config;
			motion_duration_config <= next_motion_duration_config;
			pin_a_event_route <= next_pin_a_event_route;
			pin_b_event_route <= next_pin_b_event_route;
			function_enable <= next_function_enable;
			pin_ctrl <= next_pin_ctrl;
		end
	end

	// detection; everything moves on the sample strobe except the disable clear and the read-clear request
	always_comb
	begin
		next_prev = prev;
		next_motion_run = motion_run;
		next_idle_cnt = idle_cnt;
		next_idle_state = idle_state;
		next_motion_pulse = motion_pulse;
		next_change_pulse = change_pulse;
		next_axis_hit = axis_hit;
		next_motion_latch = motion_latch;
		next_change_latch = change_latch;
		next_axis_latch = axis_latch;
		next_clear_req = clear_req || source_read;
		motion_now = 1'b0;
		go_idle = 1'b0;
		if (!enable)
		begin
			// disabled: forget history so the next slope starts from zero
			next_prev = '{default: '0};
			next_motion_run = 3'd0;
			next_idle_cnt = '0;
			next_idle_state = 1'b0;
			next_motion_pulse = 1'b0;
			next_change_pulse = 1'b0;
			next_axis_hit = 3'b000;
			next_motion_latch = 1'b0;
			next_change_latch = 1'b0;
			next_axis_latch = 3'b000;
			next_clear_req = 1'b0;
		end
		else if (sample_valid)
		begin
			next_prev = cur;
			next_motion_run = any_over ? ((motion_run == 3'd7) ? 3'd7 : motion_run + 3'd1) : 3'd0;
			motion_now = any_over && (next_motion_run > {1'b0, motion_duration});
			// a wake-up stands one period, so a spurious first slope drops after one
			next_motion_pulse = motion_now;
			next_axis_hit = motion_now ? over : 3'b000;
			if (idle_state)
			begin
				next_idle_cnt = '0;
				if (motion_now)
					next_idle_state = 1'b0;
			end
			else if (any_over)
				next_idle_cnt = '0;
			else if (idle_cnt + 1'b1 >= idle_limit)
			begin
				go_idle = 1'b1;
				next_idle_cnt = '0;
				next_idle_state = 1'b1;
			end
			else
				next_idle_cnt = idle_cnt + 1'b1;
			next_change_pulse = go_idle || (idle_state && motion_now);
			// a read clears at the next sample; a new event in that sample wins
			if (clear_req)
			begin
				next_motion_latch = 1'b0;
				next_change_latch = 1'b0;
				next_axis_latch = 3'b000;
				next_clear_req = source_read;
			end
			if (motion_now && latch_motion)
			begin
				next_motion_latch = 1'b1;
				next_axis_latch = over;
			end
			if (next_change_pulse && latch_change)
				next_change_latch = 1'b1;
		end
	end

	// pin levels; registered so the pins never glitch
	always_comb
	begin
		logic sig_a;
		logic sig_b;
		sig_a = 1'b0;
		sig_b = 1'b0;
		if (pin_a_event_route[motion_activity_pkg::RT_STATE_CHANGE])
			sig_a = state_level ? idle_state : change_flag;
		if (pin_b_event_route[motion_activity_pkg::RT_STATE_CHANGE])
			sig_b = state_level ? idle_state : change_flag;
		sig_a = sig_a || (pin_a_event_route[motion_activity_pkg::RT_MOTION] && motion_flag);
		sig_b = sig_b || (pin_b_event_route[motion_activity_pkg::RT_MOTION] && motion_flag);
		next_irq_pin_a = merge ? (sig_a || sig_b) : sig_a;
		next_irq_pin_b = merge ? 1'b0 : sig_b;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			prev <= '{default: '0};
			motion_run <= 3'd0;
			idle_cnt <= '0;
			idle_state <= 1'b0;
			motion_pulse <= 1'b0;
			change_pulse <= 1'b0;
			axis_hit <= 3'b000;
			motion_latch <= 1'b0;
			change_latch <= 1'b0;
			axis_latch <= 3'b000;
			clear_req <= 1'b0;
			irq_pin_a <= 1'b0;
			irq_pin_b <= 1'b0;
		end
		else
		begin
			prev <= next_prev;
			motion_run <= next_motion_run;
			idle_cnt <= next_idle_cnt;
			idle_state <= next_idle_state;
			motion_pulse <= next_motion_pulse;
			change_pulse <= next_change_pulse;
			axis_hit <= next_axis_hit;
			motion_latch <= next_motion_latch;
			change_latch <= next_change_latch;
			axis_latch <= next_axis_latch;
			clear_req <= next_clear_req;
			irq_pin_a <= next_irq_pin_a;
			irq_pin_b <= next_irq_pin_b;
		end
	end

endmodule : motion_activity_detector

`default_nettype wire

/* File: hw/motion_activity_pkg.sv */
// constants for the motion and activity detector: register map, fields, counts
package motion_activity_pkg;

	// register indices; byte address is four times the index
	localparam logic [6:0] IDX_FILTER_LATCH = 7'h56;
	localparam logic [6:0] IDX_THRESHOLD = 7'h5B;
	localparam logic [6:0] IDX_DURATION = 7'h5C;
	localparam logic [6:0] IDX_ROUTE_A = 7'h5E;
	localparam logic [6:0] IDX_ROUTE_B = 7'h5F;
	localparam logic [6:0] IDX_FUNC_ENABLE = 7'h58;
	localparam logic [6:0] IDX_PIN_CTRL = 7'h13;
	localparam logic [6:0] IDX_COMBINED_SRC = 7'h1A;
	localparam logic [6:0] IDX_MOTION_SRC = 7'h1B;

	localparam int ADDR_W = 9;

	// filter_latch_config fields
	localparam int FL_LATCH_IRQ = 0;
	localparam int FL_HP_SELECT = 4;
	localparam int FL_STATE_LEVEL = 6;
	// motion_threshold_config field
	localparam int TH_LSB = 0;
	localparam int TH_W = 6;
	// motion_duration_config fields
	localparam int DU_IDLE_LSB = 0;
	localparam int DU_IDLE_W = 4;
	localparam int DU_WEIGHT = 4;
	localparam int DU_MOTION_LSB = 5;
	localparam int DU_MOTION_W = 2;
	// pin route fields
	localparam int RT_MOTION = 5;
	localparam int RT_STATE_CHANGE = 7;
	// function enable and pin control
	localparam int FE_ENABLE = 7;
	localparam int PC_MERGE = 0;
	// motion source fields
	localparam int MS_Z = 0;
	localparam int MS_Y = 1;
	localparam int MS_X = 2;
	localparam int MS_MOTION = 3;
	localparam int MS_IDLE = 4;
	localparam int MS_STATE_CHANGE = 5;
	// combined source fields
	localparam int CS_MOTION = 0;
	localparam int CS_STATE_CHANGE = 1;

	localparam logic [7:0] CFG_RESET = 8'h00;

	// threshold scaling: one step is full scale over 64 or over 256
	localparam int TH_SHIFT_COARSE = 9;
	localparam int TH_SHIFT_FINE = 7;

	// idle duration in sample periods
	localparam int IDLE_UNIT = 512;
	localparam int IDLE_MIN = 16;
	localparam int IDLE_CNT_W = 13;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : motion_activity_pkg

/* File: testbench/motion_activity_checker.sv */
// concurrent checks on the detector's bus handshakes and pin timing
`timescale 1ns/1ns
`default_nettype none
module motion_activity_checker (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// register bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	// samples and pins
	input wire logic sample_valid,
	input wire logic irq_pin_a,
	input wire logic irq_pin_b
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	sequence wr_take;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence rd_take;
		arvalid && arready;
	endsequence
	write_answer_a: assert property (wr_take |-> ##[1:2] bvalid)
		else $error("write response late");
	wresp_hold_a: assert property (bvalid && !bready |=> bvalid)
		else $error("write response dropped");
	write_block_a: assert property (bvalid |-> !awready && !wready)
		else $error("write taken during response");
	read_answer_a: assert property (rd_take |=> rvalid)
		else $error("read data late");
	rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data changed before taken");
	read_block_a: assert property (rvalid |-> !arready && rdata[31:8] == 24'h000000)
		else $error("read refused or padding wrong");
	pin_a_step_a: assert property ($rose(irq_pin_a) |-> $past(sample_valid, 2))
		else $error("pin a rose off the sample step");
	pin_b_step_a: assert property ($rose(irq_pin_b) |-> $past(sample_valid, 2))
		else $error("pin b rose off the sample step");
	reset_idle_a: assert property (disable iff (1'b0) rst |=> !bvalid && !rvalid && !irq_pin_a && !irq_pin_b)
		else $error("outputs busy after reset");
endmodule : motion_activity_checker
bind motion_activity_detector motion_activity_checker u_motion_activity_checker (
	.clock, .rst, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .arvalid,
	.arready, .rvalid, .rready, .rdata, .sample_valid, .irq_pin_a, .irq_pin_b
);
`default_nettype wire

/* File: testbench/host_irq_monitor.sv */
// host side model: counts assertions seen on interrupt pin b
`timescale 1ns/1ns
`default_nettype none
module host_irq_monitor (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// pin and count
	input wire logic irq_pin_b,
	output logic [7:0] edges_b
);
	logic last_b;
	logic [7:0] next_edges_b;
	always_comb
	begin
		next_edges_b = edges_b + {7'h00, irq_pin_b & ~last_b};
	end
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			edges_b <= 8'h00;
			last_b <= 1'b0;
		end
		else
		begin
			edges_b <= next_edges_b;
			last_b <= irq_pin_b;
		end
	end
endmodule : host_irq_monitor
`default_nettype wire

/* File: testbench/tb_motion_activity_detector.sv */
// self-checking bench for the motion and activity detector
`timescale 1ns/1ns
`default_nettype none
module tb_motion_activity_detector;
	logic clock, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic sample_valid, irq_pin_a, irq_pin_b;
	logic [8:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd, seed;
	logic [1:0] bresp, rresp, rs;
	logic signed [15:0] accel_z, hp_x, hp_y, hp_z, cur, prev, lim;
	logic signed [16:0] dif;
	logic [7:0] edges_b, v;
	logic [3:0] wstrb;
	logic [6:0] cfg [5];
	logic [7:0] msk [5];
	logic signed [15:0] cor [4];
	int error_cnt, total_checks;

	motion_activity_detector #(.DATA_W(16)) u_motion_activity_detector (
		.clock, .rst, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
		.wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
		.rvalid, .rready, .rdata, .rresp, .sample_valid, .accel_x(16'sh0000), .accel_y(16'sh0000),
		.accel_z, .hp_x, .hp_y, .hp_z, .irq_pin_a, .irq_pin_b
	);
	host_irq_monitor u_host_irq_monitor (.clock, .rst, .irq_pin_b, .edges_b);

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	// fixed threshold field of 2 throughout
	function automatic logic over(input logic signed [16:0] d, input logic w);
		logic [16:0] m;
		m = d[16] ? -d : d;
		return m > (17'h00002 << (w ? 7 : 9));
	endfunction : over
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, exp, seen);
		end
	endtask : check
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	// one write (w=1) or read; response stalls are random
	task automatic acc(input logic w, input logic [6:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clock);
		awvalid <= w;
		wvalid <= w;
		arvalid <= !w;
		awaddr <= {idx, 2'b00};
		araddr <= {idx, 2'b00};
		wdata <= {24'h000000, d};
		do
		begin
			@(posedge clock);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (arready) arvalid <= 1'b0;
			if (!(bready | rready) && rnd() > 32'h7FFFFFFF) {bready, rready} <= {w, !w};
			n++;
		end
		while (!(w ? bvalid && bready : rvalid && rready) && n < 99);
		{bready, rready} <= 2'b00;
		rd = rdata;
		rs = w ? bresp : rresp;
		if (n >= 99) error_cnt++;
	endtask : acc
	// one sample strobe, then the rest of a six-clock output period
	task automatic smp(input logic signed [15:0] a, hx, hy, hz);
		@(posedge clock);
		sample_valid <= 1'b1;
		accel_z <= a;
		hp_x <= hx;
		hp_y <= hy;
		hp_z <= hz;
		@(posedge clock);
		sample_valid <= 1'b0;
		repeat (4) @(posedge clock);
	endtask : smp

	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial
	begin
		#400000;
		error_cnt++;
		close_out();
	end
	initial
	begin
		seed = 32'h3F1A7F34;
		wstrb = 4'hF;
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, sample_valid} = 6'h00;
		{awaddr, araddr, wdata} = 50'h0;
		{accel_z, hp_x, hp_y, hp_z} = 64'h0;
		cfg = '{motion_activity_pkg::IDX_FILTER_LATCH, motion_activity_pkg::IDX_THRESHOLD,
			motion_activity_pkg::IDX_DURATION, motion_activity_pkg::IDX_ROUTE_A, motion_activity_pkg::IDX_ROUTE_B};
		msk = '{8'h51, 8'h3F, 8'h7F, 8'hA0, 8'hA0};
		cor = '{16'sh1000, 16'sh1800, 16'sh0FFE, 16'shF7FC};
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++)
		begin
			acc(1'b0, cfg[i], 8'h00);
			check("reset value", rd, 32'h0);
			v = rnd() & msk[i];
			acc(1'b1, cfg[i], v);
			acc(1'b0, cfg[i], 8'h00);
			check("readback", rd, {24'h000000, v});
			acc(1'b1, cfg[i], 8'h00);
		end
		acc(1'b0, 7'h7F, 8'h00);
		check("unmapped read", {rs, rd[29:0]}, {motion_activity_pkg::RESP_SLVERR, 30'h0});
		acc(1'b1, 7'h7F, 8'hFF);
		check("unmapped write", rs, motion_activity_pkg::RESP_SLVERR);
		// a write with the low byte lane off must leave the register alone
		wstrb <= 4'h0;
		acc(1'b1, motion_activity_pkg::IDX_THRESHOLD, 8'h3F);
		wstrb <= 4'hF;
		check("masked write resp", rs, motion_activity_pkg::RESP_OKAY);
		acc(1'b0, motion_activity_pkg::IDX_THRESHOLD, 8'h00);
		check("masked write", rd, 32'h0);
		$display("test registers done");
		// routed before enable on purpose so the start-up event is seen
		acc(1'b1, motion_activity_pkg::IDX_THRESHOLD, 8'h02);
		acc(1'b1, motion_activity_pkg::IDX_ROUTE_A, 8'h20);
		acc(1'b1, motion_activity_pkg::IDX_FUNC_ENABLE, 8'h80);
		prev = 16'sh0000;
		for (int i = 0; i < 12; i++)
		begin
			cur = (i < 4) ? cor[i] : $signed(16'(rnd() % 16384)) - 16'sh2000;
			smp(cur, 16'sh0000, 16'sh0000, 16'sh0000);
			dif = cur - prev;
			check("slope pin", irq_pin_a, over(dif >>> 1, 1'b0));
			prev = cur;
		end
		$display("test slope done");
		acc(1'b1, motion_activity_pkg::IDX_FILTER_LATCH, 8'h10);
		for (int k = 0; k < 6; k++)
		begin
			if (k % 3 == 0) acc(1'b1, motion_activity_pkg::IDX_DURATION, (k > 0) ? 8'h10 : 8'h00);
			lim = (k < 3) ? 16'sh0400 : 16'sh0100;
			cur = (k % 3 == 0) ? lim : (k % 3 == 1) ? lim + 16'sh0001 : -lim - 16'sh0001;
			smp(16'sh4000, 16'sh0000, 16'sh0000, cur);
			check("hp pin", irq_pin_a, over(cur, k >= 3));
		end
		acc(1'b1, motion_activity_pkg::IDX_DURATION, 8'h20);
		for (int k = 0; k < 4; k++)
		begin
			smp(16'sh4000, 16'sh0000, 16'sh0000, (k == 1 || k == 2) ? 16'sh07D0 : 16'sh0000);
			check("duration pin", irq_pin_a, k == 2);
		end
		$display("test filter and duration done");
		acc(1'b1, motion_activity_pkg::IDX_DURATION, 8'h00);
		acc(1'b1, motion_activity_pkg::IDX_ROUTE_A, 8'h00);
		acc(1'b1, motion_activity_pkg::IDX_ROUTE_B, 8'h80);
		smp(16'sh4000, 16'sh0000, 16'sh0000, 16'sh07D0);
		for (int i = 0; i < 32; i++)
		begin
			smp(16'sh4000, $signed(16'(rnd() % 2049)) - 16'sh0400, 16'sh0000, 16'sh0000);
			if (i < 16) check("idle pulse", irq_pin_b, i == 15);
			if (i == 15) acc(1'b0, motion_activity_pkg::IDX_MOTION_SRC, 8'h00);
			if (i == 15) check("idle flags", rd[5:4], 2'b11);
			if (i == 16) acc(1'b1, motion_activity_pkg::IDX_PIN_CTRL, 8'h00);
		end
		smp(16'sh4000, 16'sh0000, 16'sh07D0, 16'sh0000);
		check("active pulse", irq_pin_b, 1'b1);
		acc(1'b0, motion_activity_pkg::IDX_MOTION_SRC, 8'h00);
		check("active flag", rd[motion_activity_pkg::MS_IDLE], 1'b0);
		check("host edges", edges_b, 8'h02);
		smp(16'sh4000, 16'sh0000, 16'sh0000, 16'sh0000);
		$display("test idle done");
		acc(1'b1, motion_activity_pkg::IDX_FILTER_LATCH, 8'h50);
		acc(1'b1, motion_activity_pkg::IDX_PIN_CTRL, 8'h01);
		for (int i = 0; i < 17; i++)
		begin
			smp(16'sh4000, 16'sh0000, 16'sh0000, (i == 16) ? 16'sh07D0 : 16'sh0000);
			check("level pin", irq_pin_a, i == 14 || i == 15);
			check("merged pin", irq_pin_b, 1'b0);
		end
		acc(1'b1, motion_activity_pkg::IDX_PIN_CTRL, 8'h00);
		acc(1'b1, motion_activity_pkg::IDX_ROUTE_B, 8'h00);
		$display("test level and merge done");
		acc(1'b1, motion_activity_pkg::IDX_FILTER_LATCH, 8'h11);
		acc(1'b1, motion_activity_pkg::IDX_ROUTE_A, 8'h20);
		for (int i = 0; i < 4; i++)
		begin
			smp(16'sh4000, 16'sh0000, 16'sh0000, (i == 0) ? 16'sh07D0 : 16'sh0000);
			check("latched pin", irq_pin_a, i < 3);
			if (i == 1) acc(1'b1, motion_activity_pkg::IDX_THRESHOLD, 8'h02);
			if (i == 2) acc(1'b0, motion_activity_pkg::IDX_COMBINED_SRC, 8'h00);
			if (i == 2) check("combined flag", rd[motion_activity_pkg::CS_MOTION], 1'b1);
		end
		$display("test latch done");
		acc(1'b1, motion_activity_pkg::IDX_FUNC_ENABLE, 8'h00);
		smp(16'sh4000, 16'sh0000, 16'sh0000, 16'sh07D0);
		check("disabled pin", irq_pin_a, 1'b0);
		acc(1'b0, motion_activity_pkg::IDX_MOTION_SRC, 8'h00);
		check("disabled source", rd, 32'h0);
		$display("test disable done");
		close_out();
	end
endmodule : tb_motion_activity_detector
`default_nettype wire
